// *** dv/measurement_status_summary_chain_tb.sv ***
`timescale 1ns/1ps
module measurement_status_summary_chain_tb;
  import mss_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, meas_summary, irq, e, to;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [EVT_W-1:0] meas_src = EVT_RESET, inst_src = EVT_RESET;
  logic [EVT_W-1:0] sum_src = EVT_RESET;
  int n_fail = 0, checked = 0, seed = 89171;
  logic [15:0] me, ie, se, men, ien, sen;
  logic [2:0] st, msk;
  always #2 pclk = ~pclk;
  mss_status_chain uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .meas_src, .inst_src,
    .sum_src, .meas_summary, .irq);
  mss_host host (.pclk, .pready, .pslverr, .prdata, .psel, .penable,
    .pwrite, .paddr, .pwdata);
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    host.xfer(w, a, 32'(d), r, e, to);
    chk("timeout", to, 0);
    if (to) end_of_test();
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input int x);
    bus(1'b0, a, 0);
    chk(nm, r, 32'(x));
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd("meas_en", ADDR_MEAS_EN, 0);
    rd("inst_en", ADDR_INST_EN, 0);
    rd("unmapped", 8'h24, 0);
    chk("pslverr", e, 1);
    bus(1'b1, ADDR_INST_EVT, 32'h0000_FFFF);
    rd("inst_evt", ADDR_INST_EVT, 0);
    bus(1'b1, ADDR_MEAS_EN, 32'h0000_2000);
    rd("meas_en", ADDR_MEAS_EN, 8192);
    bus(1'b1, ADDR_INST_EN, 32'h0000_FFFF);
    bus(1'b1, ADDR_INST_EN, 32'h0000_0002);
    rd("inst_en", ADDR_INST_EN, 2);
    for (int i = 0; i < 8; i++) begin
      {men, ien, sen} = 48'({$random(seed), $random(seed)});
      msk = 3'($random(seed));
      bus(1'b1, ADDR_MEAS_EN, men);
      bus(1'b1, ADDR_INST_EN, ien);
      bus(1'b1, ADDR_SUM_EN, sen);
      bus(1'b1, ADDR_IRQ_MASK, msk);
      {me, ie, se} = 48'({$random(seed), $random(seed)});
      // One-cycle source pulses show that event bits latch and hold.
      {meas_src, inst_src, sum_src} <= {me, ie, se};
      @(posedge pclk);
      {meas_src, inst_src, sum_src} <= 48'h0000_0000_0000;
      repeat (4) @(posedge pclk);
      if (|(se & sen)) ie[INST_SUM_POS] = 1'b1;
      if (|(ie & ien)) me[INSTRUMENT_SUMMARY_BIT_POS] = 1'b1;
      st = {|se, |ie, |me};
      chk("meas_summary", meas_summary, |(me & men));
      chk("irq", irq, |(st & msk));
      rd("sum_en", ADDR_SUM_EN, sen);
      rd("meas_en", ADDR_MEAS_EN, men);
      rd("status_byte", ADDR_STB, |(me & men));
      rd("irq_status", ADDR_IRQ_ST, st);
      bus(1'b1, ADDR_IRQ_ST, 32'h0000_0007);
      rd("sum_evt", ADDR_SUM_EVT, se);
      rd("inst_evt", ADDR_INST_EVT, ie);
      rd("meas_evt", ADDR_MEAS_EVT, me);
      rd("sum_evt", ADDR_SUM_EVT, 0);
      rd("inst_evt", ADDR_INST_EVT, 0);
      rd("meas_evt", ADDR_MEAS_EVT, 0);
      chk("irq", irq, 0);
    end
    bus(1'b1, ADDR_INST_EN, 32'h0000_0002);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("inst_en", ADDR_INST_EN, 0);
    rd("meas_en", ADDR_MEAS_EN, 0);
    chk("meas_summary", meas_summary, 0);
    end_of_test();
  end
endmodule

// *** dv/mss_host.sv ***
`timescale 1ns/1ps
module mss_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0000_0000
);
  // Mask values are handed over already converted to binary.
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e,
    output logic to);
    int n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    r = prdata;
    e = pslverr;
    to = pready !== 1'b1;
    // Inverted data on release so a stale word never looks valid.
    {psel, penable, pwdata} <= {2'b00, ~d};
  endtask
endmodule

// *** hw/mss_pkg.sv ***
package mss_pkg;
  localparam int unsigned EVT_W = 16;
  localparam logic [7:0] ADDR_MEAS_EVT = 8'h00;
  localparam logic [7:0] ADDR_MEAS_EN = 8'h04;
  localparam logic [7:0] ADDR_INST_EVT = 8'h08;
  localparam logic [7:0] ADDR_INST_EN = 8'h0C;
  localparam logic [7:0] ADDR_SUM_EVT = 8'h10;
  localparam logic [7:0] ADDR_SUM_EN = 8'h14;
  localparam logic [7:0] ADDR_STB = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  localparam int unsigned INSTRUMENT_SUMMARY_BIT_POS = 13;
  localparam int unsigned INST_SUM_POS = 1;
  localparam int unsigned STB_MSB_POS = 0;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_MEAS = 0;
  localparam int unsigned IRQ_INST = 1;
  localparam int unsigned IRQ_SUM = 2;
  localparam logic [EVT_W-1:0] EN_RESET = 16'h0000;
  localparam logic [EVT_W-1:0] EVT_RESET = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// *** hw/mss_status_chain.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Reading the instrument event register returns it and then clears it.
// - The instrument enable mask is read/write and resets to zero.
// - Any instrument event bit with its enable bit set sets the summary bit.
// - The instrument summary bit is bit 13 of the measurement registers.
// - Reading the summary event register returns it and then clears it.
// - Every read returns the plain binary-weighted value of the register.
// - Mask values may be written in binary, hex or decimal notation.
// - Writing 2 to the instrument enable mask sets bit 1 only.
// - Reading an enable mask returns its last written value, unchanged.
// - A masked measurement event sets the status byte summary bit.
// - A masked summary event sets bit 1 of the instrument event register.
module mss_status_chain
  import mss_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [EVT_W-1:0] meas_src,
  input wire logic [EVT_W-1:0] inst_src,
  input wire logic [EVT_W-1:0] sum_src,
  output logic meas_summary,
  output logic irq
);
  logic [EVT_W-1:0] meas_q, meas_d, meas_en_q, meas_en_d;
  logic [EVT_W-1:0] inst_q, inst_d, inst_en_q, inst_en_d;
  logic [EVT_W-1:0] sum_q, sum_d, sum_en_q, sum_en_d;
  logic [EVT_W-1:0] meas_set, inst_set, rd_bits;
  logic [IRQ_W-1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d, irq_set;
  logic [31:0] prdata_q, prdata_d;
  logic stb_q, stb_d;
  logic setup_rd, acc, rd_acc, wr_acc;

  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_MEAS_EVT || a == ADDR_MEAS_EN || a == ADDR_INST_EVT ||
           a == ADDR_INST_EN || a == ADDR_SUM_EVT || a == ADDR_SUM_EN ||
           a == ADDR_STB || a == ADDR_IRQ_ST || a == ADDR_IRQ_MASK;
  endfunction

  function automatic logic [31:0] widen(input logic [EVT_W-1:0] v);
    return {{(32-EVT_W){1'b0}}, v};
  endfunction

  assign setup_rd = psel && !penable && !pwrite;
  assign acc = psel && penable;
  assign rd_acc = acc && !pwrite;
  assign wr_acc = acc && pwrite;
  // Read data is latched in the setup cycle, so the access always ends at
  // once and prdata comes straight from a flip-flop.
  assign pready = 1'b1;
  assign pslverr = acc && !mapped(paddr);
  assign prdata = prdata_q;
  assign meas_summary = stb_q;
  assign irq = |(irq_st_q & irq_mask_q);

  // The chain is level driven: while an upstream bit stays set and enabled,
  // the downstream summary bit is set again on every edge.
  always_comb begin
    meas_set = meas_src;
    meas_set[INSTRUMENT_SUMMARY_BIT_POS] = meas_src[INSTRUMENT_SUMMARY_BIT_POS] | (|(inst_q & inst_en_q));
    inst_set = inst_src;
    inst_set[INST_SUM_POS] = inst_src[INST_SUM_POS] | (|(sum_q & sum_en_q));
  end

  always_comb begin
    prdata_d = prdata_q;
    if (setup_rd) begin
      unique case (paddr)
        ADDR_MEAS_EVT: prdata_d = widen(meas_q);
        ADDR_MEAS_EN: prdata_d = widen(meas_en_q);
        ADDR_INST_EVT: prdata_d = widen(inst_q);
        ADDR_INST_EN: prdata_d = widen(inst_en_q);
        ADDR_SUM_EVT: prdata_d = widen(sum_q);
        ADDR_SUM_EN: prdata_d = widen(sum_en_q);
        ADDR_STB: prdata_d = {31'h0000_0000, stb_q} << STB_MSB_POS;
        ADDR_IRQ_ST: prdata_d = {{(32-IRQ_W){1'b0}}, irq_st_q};
        ADDR_IRQ_MASK: prdata_d = {{(32-IRQ_W){1'b0}}, irq_mask_q};
        default: prdata_d = RDATA_RESET;
      endcase
    end
  end

  // Only the bits that were reported are cleared, and a new event wins over
  // the clear, so an event landing during the read is never lost.
  always_comb begin
    rd_bits = prdata_q[EVT_W-1:0];
    meas_d = meas_q | meas_set;
    inst_d = inst_q | inst_set;
    sum_d = sum_q | sum_src;
    if (rd_acc && paddr == ADDR_MEAS_EVT) begin
      meas_d = (meas_q & ~rd_bits) | meas_set;
    end
    if (rd_acc && paddr == ADDR_INST_EVT) begin
      inst_d = (inst_q & ~rd_bits) | inst_set;
    end
    if (rd_acc && paddr == ADDR_SUM_EVT) begin
      sum_d = (sum_q & ~rd_bits) | sum_src;
    end
    stb_d = |(meas_q & meas_en_q);
  end

  // Notation of the value (#b, #h or decimal) is resolved by the command
  // parser; the mask port takes the resulting binary word as is.
  always_comb begin
    meas_en_d = meas_en_q;
    inst_en_d = inst_en_q;
    sum_en_d = sum_en_q;
    irq_mask_d = irq_mask_q;
    if (wr_acc) begin
      unique case (paddr)
        ADDR_MEAS_EN: meas_en_d = pwdata[EVT_W-1:0];
        ADDR_INST_EN: inst_en_d = pwdata[EVT_W-1:0];
        ADDR_SUM_EN: sum_en_d = pwdata[EVT_W-1:0];
        ADDR_IRQ_MASK: irq_mask_d = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_MEAS] = |(meas_set & ~meas_q);
    irq_set[IRQ_INST] = |(inst_set & ~inst_q);
    irq_set[IRQ_SUM] = |(sum_src & ~sum_q);
    irq_st_d = irq_st_q;
    if (wr_acc && paddr == ADDR_IRQ_ST) begin
      irq_st_d = irq_st_q & ~pwdata[IRQ_W-1:0];
    end
    irq_st_d = irq_st_d | irq_set;
  end

  // One register stage per chain step keeps each hop to one edge, so a
  // summary event reaches the status byte three edges after it latches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_q <= EVT_RESET;
      inst_q <= EVT_RESET;
      sum_q <= EVT_RESET;
      meas_en_q <= EN_RESET;
      inst_en_q <= EN_RESET;
      sum_en_q <= EN_RESET;
      irq_st_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
      prdata_q <= RDATA_RESET;
      stb_q <= 1'b0;
    end else begin
      meas_q <= meas_d;
      inst_q <= inst_d;
      sum_q <= sum_d;
      meas_en_q <= meas_en_d;
      inst_en_q <= inst_en_d;
      sum_en_q <= sum_en_d;
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      prdata_q <= prdata_d;
      stb_q <= stb_d;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_inst_read_clear: assert property (
    (rd_acc && paddr == ADDR_INST_EVT && inst_set == '0)
      |=> (inst_q & $past(prdata_q[EVT_W-1:0])) == '0)
    else $error("instrument event not cleared by read");
  a_inst_en_write: assert property (
    (wr_acc && paddr == ADDR_INST_EN)
      |=> inst_en_q == $past(pwdata[EVT_W-1:0]))
    else $error("instrument enable does not hold written value");
  a_en_read_stable: assert property (
    (rd_acc && paddr == ADDR_INST_EN) |=> $stable(inst_en_q) ##0
      prdata == widen(inst_en_q))
    else $error("enable read changed or misreported the mask");
  a_instrument_summary_bit_set: assert property (
    (|(inst_q & inst_en_q)) |=> meas_q[INSTRUMENT_SUMMARY_BIT_POS])
    else $error("summary bit 13 not set by masked instrument event");
  a_sum_to_inst: assert property (
    (|(sum_q & sum_en_q)) |=> inst_q[INST_SUM_POS])
    else $error("instrument bit 1 not set by masked summary event");
  a_stb_summary: assert property (
    (|(meas_q & meas_en_q)) |=> meas_summary)
    else $error("status byte summary not raised");
  a_evt_hold: assert property (
    (inst_q[0] && !(rd_acc && paddr == ADDR_INST_EVT)) |=> inst_q[0])
    else $error("instrument event bit dropped without read");
  a_read_value: assert property (
    (setup_rd && paddr == ADDR_SUM_EVT) |=> prdata == widen($past(sum_q)))
    else $error("read value differs from register");
  a_sum_read_clear: assert property (
    (rd_acc && paddr == ADDR_SUM_EVT && sum_src == '0)
      |=> (sum_q & $past(prdata_q[EVT_W-1:0])) == '0)
    else $error("summary event not cleared by read");
  a_irq_level: assert property (
    (|(irq_st_q & irq_mask_q)) |-> irq)
    else $error("interrupt low with unmasked status");

  // The chain must not raise a summary bit on its own: each one below
  // checks that an idle upstream leaves the downstream bit clear.
  a_instrument_summary_bit_quiet: assert property (
    (!meas_q[INSTRUMENT_SUMMARY_BIT_POS] && !meas_src[INSTRUMENT_SUMMARY_BIT_POS] &&
      !(|(inst_q & inst_en_q))) |=> !meas_q[INSTRUMENT_SUMMARY_BIT_POS])
    else $error("summary bit 13 set with no masked instrument event");

  a_inst_bit_quiet: assert property (
    (!inst_q[INST_SUM_POS] && !inst_src[INST_SUM_POS] &&
      !(|(sum_q & sum_en_q))) |=> !inst_q[INST_SUM_POS])
    else $error("instrument bit 1 set with no masked summary event");

  a_stb_quiet: assert property (
    (!(|(meas_q & meas_en_q))) |=> !meas_summary)
    else $error("status byte summary high with no masked event");

  // Source pulses must be caught on the edge they stand at, even while a
  // read is clearing the same register.
  a_meas_latch: assert property (
    meas_src[0] |=> meas_q[0])
    else $error("measurement event bit missed its source");

  a_inst_latch: assert property (
    inst_src[0] |=> inst_q[0])
    else $error("instrument event bit missed its source");

  a_sum_latch: assert property (
    sum_src[0] |=> sum_q[0])
    else $error("summary event bit missed its source");

  a_sum_hold: assert property (
    (sum_q[0] && !(rd_acc && paddr == ADDR_SUM_EVT)) |=> sum_q[0])
    else $error("summary event bit dropped without read");

  a_meas_hold: assert property (
    (meas_q[0] && !(rd_acc && paddr == ADDR_MEAS_EVT)) |=> meas_q[0])
    else $error("measurement event bit dropped without read");

  a_meas_read_clear: assert property (
    (rd_acc && paddr == ADDR_MEAS_EVT && meas_set == '0)
      |=> (meas_q & $past(prdata_q[EVT_W-1:0])) == '0)
    else $error("measurement event not cleared by read");

  // Reads report the register as it stood at the setup edge.
  a_inst_read_value: assert property (
    (setup_rd && paddr == ADDR_INST_EVT)
      |=> prdata == widen($past(inst_q)))
    else $error("instrument event read differs from register");

  a_meas_read_value: assert property (
    (setup_rd && paddr == ADDR_MEAS_EVT)
      |=> prdata == widen($past(meas_q)))
    else $error("measurement event read differs from register");

  a_stb_read: assert property (
    (setup_rd && paddr == ADDR_STB)
      |=> prdata[STB_MSB_POS] == $past(stb_q))
    else $error("status byte read differs from summary");

  // Masks change only through a write to their own address.
  a_meas_en_write: assert property (
    (wr_acc && paddr == ADDR_MEAS_EN)
      |=> meas_en_q == $past(pwdata[EVT_W-1:0]))
    else $error("measurement enable does not hold written value");

  a_sum_en_write: assert property (
    (wr_acc && paddr == ADDR_SUM_EN)
      |=> sum_en_q == $past(pwdata[EVT_W-1:0]))
    else $error("summary enable does not hold written value");

  a_inst_en_keep: assert property (
    !(wr_acc && paddr == ADDR_INST_EN) |=> $stable(inst_en_q))
    else $error("instrument enable changed without a write");

  a_meas_en_keep: assert property (
    !(wr_acc && paddr == ADDR_MEAS_EN) |=> $stable(meas_en_q))
    else $error("measurement enable changed without a write");

  a_sum_en_keep: assert property (
    !(wr_acc && paddr == ADDR_SUM_EN) |=> $stable(sum_en_q))
    else $error("summary enable changed without a write");

  // The interrupt is a plain level of unmasked status, and a write of
  // ones clears status unless a new event lands in the same cycle.
  a_irq_quiet: assert property (
    !(|(irq_st_q & irq_mask_q)) |-> !irq)
    else $error("interrupt high with no unmasked status");

  a_irq_clear: assert property (
    (wr_acc && paddr == ADDR_IRQ_ST && (&pwdata[IRQ_W-1:0]) &&
      irq_set == '0) |=> irq_st_q == '0)
    else $error("interrupt status not cleared by write");

  a_irq_set_wins: assert property (
    irq_set[IRQ_SUM] |=> irq_st_q[IRQ_SUM])
    else $error("new summary event missed in interrupt status");

  c_chain: cover property ((|(sum_q & sum_en_q)) ##2 meas_q[INSTRUMENT_SUMMARY_BIT_POS]);
  c_read_clear: cover property (
    rd_acc && paddr == ADDR_INST_EVT && inst_q != '0);
  c_irq: cover property (irq ##[1:20] !irq);
  c_stb_pulse: cover property (meas_summary ##1 !meas_summary);
  c_en_read: cover property (rd_acc && paddr == ADDR_INST_EN);
endmodule
